/* File: hw/rail_discharge_control_regs.sv */
// What this block does
// - while a rail is enabled its two-bit discharge field is forced to the no-discharge code.
// - field codes mean 00 none, 01 a 100 ohm path, 10 a 200 ohm path, 11 a 500 ohm path.
// - register 0x40 holds buck four, three, two and one fields in bits 7:6, 5:4, 3:2 and 1:0.
// - register 0x41 holds ldo two, load switch one, buck six and buck five in 7:6 down to 1:0.
// - register 0x42 exists and its fields clear on rail enable like the others.
// - reset values are fixed at build time, 100 ohm everywhere, load switch one selectable.
`timescale 1ns/10ps
module rail_discharge_control_regs
#(
  parameter logic [6:0] BUS_ADDR        = drain_pkg::BUS_ADDR_DEF,
  parameter logic [1:0] LOAD_SW_RESET   = drain_pkg::CODE_100
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic [10:0] rail_en,
  output logic      [32:0] drain_path
);

  localparam int FLAT_W = drain_pkg::NUM_RAILS * drain_pkg::FIELD_W;

  logic                        scl_q;
  logic                        sda_q;
  logic                        scl_prev_q;
  logic                        sda_prev_q;
  logic                        start_det;
  logic                        stop_det;
  logic                        scl_rise;
  logic                        scl_fall;
  drain_pkg::serial_state_t    state_q;
  logic [3:0]                  cnt_q;
  logic [7:0]                  rx_q;
  logic [7:0]                  tx_q;
  logic [7:0]                  ptr_q;
  logic                        read_q;
  logic                        mack_q;
  logic                        wr_q;
  logic [7:0]                  wr_addr_q;
  logic [7:0]                  wr_data_q;
  logic [FLAT_W-1:0]           field_flat;
  logic [7:0]                  rd_byte;
  logic                        drive_low;

  // pins are synchronous; one stage gives a clean edge reference
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else if (ce)
    begin
      scl_q      <= scl_in;
      sda_q      <= sda_in;
      scl_prev_q <= scl_q;
      sda_prev_q <= sda_q;
    end
  end

  assign start_det = scl_q && scl_prev_q && sda_prev_q && !sda_q;
  assign stop_det  = scl_q && scl_prev_q && !sda_prev_q && sda_q;
  assign scl_rise  = scl_q && !scl_prev_q;
  assign scl_fall  = !scl_q && scl_prev_q;

  always_comb
  begin
    unique case (ptr_q)
      drain_pkg::REG_A_OFS: rd_byte = field_flat[7:0];
      drain_pkg::REG_B_OFS: rd_byte = field_flat[15:8];
      drain_pkg::REG_C_OFS: rd_byte = {drain_pkg::RSVD_C, field_flat[21:16]};
      default:              rd_byte = drain_pkg::UNMAPPED_DATA;
    endcase
  end

  // serial protocol: address, pointer, then data with auto increment
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= drain_pkg::ST_IDLE;
      cnt_q   <= '0;
      rx_q    <= '0;
      tx_q    <= '0;
      ptr_q   <= drain_pkg::PTR_RESET;
      read_q  <= 1'b0;
      mack_q  <= 1'b0;
    end
    else if (ce)
    begin
      if (start_det)
      begin
        state_q <= drain_pkg::ST_ADDR;
        cnt_q   <= '0;
      end
      else if (stop_det)
      begin
        state_q <= drain_pkg::ST_IDLE;
      end
      else
      begin
        if (scl_rise)
        begin
          rx_q  <= {rx_q[6:0], sda_q};
          cnt_q <= cnt_q + 4'h1;
          if (state_q == drain_pkg::ST_RDAT_ACK)
          begin
            mack_q <= !sda_q;
          end
        end
        if (scl_fall)
        begin
          unique case (state_q)
            drain_pkg::ST_IDLE:
            begin
              state_q <= drain_pkg::ST_IDLE;
            end
            drain_pkg::ST_ADDR:
            begin
              if (cnt_q == drain_pkg::BITS_PER_BYTE)
              begin
                if (rx_q[7:1] == BUS_ADDR)
                begin
                  state_q <= drain_pkg::ST_ADDR_ACK;
                  read_q  <= rx_q[0];
                end
                else
                begin
                  state_q <= drain_pkg::ST_IDLE;
                end
              end
            end
            drain_pkg::ST_ADDR_ACK:
            begin
              cnt_q <= '0;
              if (read_q)
              begin
                state_q <= drain_pkg::ST_RDATA;
                tx_q    <= rd_byte;
                ptr_q   <= ptr_q + 8'h1;
              end
              else
              begin
                state_q <= drain_pkg::ST_PTR;
              end
            end
            drain_pkg::ST_PTR:
            begin
              if (cnt_q == drain_pkg::BITS_PER_BYTE)
              begin
                state_q <= drain_pkg::ST_PTR_ACK;
                ptr_q   <= rx_q;
              end
            end
            drain_pkg::ST_PTR_ACK,
            drain_pkg::ST_WDAT_ACK:
            begin
              state_q <= drain_pkg::ST_WDATA;
              cnt_q   <= '0;
            end
            drain_pkg::ST_WDATA:
            begin
              if (cnt_q == drain_pkg::BITS_PER_BYTE)
              begin
                state_q <= drain_pkg::ST_WDAT_ACK;
                ptr_q   <= ptr_q + 8'h1;
              end
            end
            drain_pkg::ST_RDATA:
            begin
              if (cnt_q == drain_pkg::BITS_PER_BYTE)
              begin
                state_q <= drain_pkg::ST_RDAT_ACK;
              end
              else
              begin
                tx_q <= {tx_q[6:0], 1'b0};
              end
            end
            drain_pkg::ST_RDAT_ACK:
            begin
              cnt_q <= '0;
              if (mack_q)
              begin
                state_q <= drain_pkg::ST_RDATA;
                tx_q    <= rd_byte;
                ptr_q   <= ptr_q + 8'h1;
              end
              else
              begin
                state_q <= drain_pkg::ST_IDLE;
              end
            end
          endcase
        end
      end
    end
  end

  // one-cycle write strobe taken as the data byte completes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q      <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end
    else if (ce)
    begin
      wr_q <= !start_det && !stop_det && scl_fall
              && state_q == drain_pkg::ST_WDATA
              && cnt_q == drain_pkg::BITS_PER_BYTE;
      wr_addr_q <= ptr_q;
      wr_data_q <= rx_q;
    end
  end

  assign drive_low = (state_q == drain_pkg::ST_ADDR_ACK)
                  || (state_q == drain_pkg::ST_PTR_ACK)
                  || (state_q == drain_pkg::ST_WDAT_ACK)
                  || (state_q == drain_pkg::ST_RDATA && !tx_q[7]);

  // open drain: only ever pull low, release otherwise
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_out  <= 1'b1;
      sda_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      sda_out  <= !drive_low;
      sda_oe_n <= !drive_low;
    end
  end

  generate
    for (genvar g = 0; g < drain_pkg::NUM_RAILS; g++)
    begin : rail
      localparam logic [7:0] OFS = drain_pkg::REG_A_OFS
                                 + 8'(g / drain_pkg::FIELDS_PER_REG);
      localparam int         LSB = (g % drain_pkg::FIELDS_PER_REG) * drain_pkg::FIELD_W;
      localparam logic [1:0] RST = (g == drain_pkg::LOAD_SW_RAIL) ? LOAD_SW_RESET
                                                                   : drain_pkg::CODE_100;
      drain_field_if fif ();

      assign fif.wr_stb  = wr_q && (wr_addr_q == OFS);
      assign fif.wr_code = wr_data_q[LSB +: drain_pkg::FIELD_W];
      assign fif.rail_on = rail_en[g];
      assign field_flat[g*drain_pkg::FIELD_W +: drain_pkg::FIELD_W] = fif.field;
      assign drain_path[g*drain_pkg::PATH_W +: drain_pkg::PATH_W]   = fif.path;

      drain_field
      #(
        .RESET_CODE (RST)
      )
      u_field
      (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .fif     (fif.field_m)
      );
    end
  endgenerate

endmodule

/* File: common/drain_pkg.sv */
package drain_pkg;
  localparam logic [7:0] REG_A_OFS      = 8'h40;
  localparam logic [7:0] REG_B_OFS      = 8'h41;
  localparam logic [7:0] REG_C_OFS      = 8'h42;
  localparam int         NUM_RAILS      = 11;
  localparam int         FIELD_W        = 2;
  localparam int         FIELDS_PER_REG = 4;
  localparam int         PATH_W         = 3;
  localparam int         LOAD_SW_RAIL   = 6;
  localparam logic [1:0] CODE_NONE      = 2'h0;
  localparam logic [1:0] CODE_100       = 2'h1;
  localparam logic [1:0] CODE_200       = 2'h2;
  localparam logic [1:0] CODE_500       = 2'h3;
  localparam logic [2:0] PATH_OFF       = 3'h0;
  localparam logic [2:0] PATH_100       = 3'h1;
  localparam logic [2:0] PATH_200       = 3'h2;
  localparam logic [2:0] PATH_500       = 3'h4;
  localparam logic [1:0] RSVD_C         = 2'h0;
  localparam logic [7:0] UNMAPPED_DATA  = 8'h00;
  localparam logic [7:0] PTR_RESET      = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [6:0] BUS_ADDR_DEF   = 7'h2A;

  typedef enum logic [8:0] {
    ST_IDLE     = 9'b0_0000_0001,
    ST_ADDR     = 9'b0_0000_0010,
    ST_ADDR_ACK = 9'b0_0000_0100,
    ST_PTR      = 9'b0_0000_1000,
    ST_PTR_ACK  = 9'b0_0001_0000,
    ST_WDATA    = 9'b0_0010_0000,
    ST_WDAT_ACK = 9'b0_0100_0000,
    ST_RDATA    = 9'b0_1000_0000,
    ST_RDAT_ACK = 9'b1_0000_0000
  } serial_state_t;
endpackage

/* File: common/drain_field_if.sv */
`timescale 1ns/10ps
interface drain_field_if;
  logic       wr_stb;
  logic [1:0] wr_code;
  logic       rail_on;
  logic [1:0] field;
  logic [2:0] path;

  modport regs
  (
    output wr_stb,
    output wr_code,
    output rail_on,
    input  field,
    input  path
  );

  modport field_m
  (
    input  wr_stb,
    input  wr_code,
    input  rail_on,
    output field,
    output path
  );
endinterface

/* File: hw/drain_field.sv */
`timescale 1ns/10ps
module drain_field
#(
  parameter logic [1:0] RESET_CODE = drain_pkg::CODE_100
)
(
  input  wire logic     sys_clk,
  input  wire logic     rst_n,
  input  wire logic     ce,
  drain_field_if.field_m fif
);

  // enable forcing wins over a host write landing in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fif.field <= RESET_CODE;
    end
    else if (ce)
    begin
      if (fif.rail_on)
      begin
        fif.field <= drain_pkg::CODE_NONE;
      end
      else if (fif.wr_stb)
      begin
        fif.field <= fif.wr_code;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fif.path <= drain_pkg::PATH_OFF;
    end
    else if (ce)
    begin
      if (fif.rail_on)
      begin
        fif.path <= drain_pkg::PATH_OFF;
      end
      else
      begin
        unique case (fif.field)
          drain_pkg::CODE_NONE: fif.path <= drain_pkg::PATH_OFF;
          drain_pkg::CODE_100:  fif.path <= drain_pkg::PATH_100;
          drain_pkg::CODE_200:  fif.path <= drain_pkg::PATH_200;
          drain_pkg::CODE_500:  fif.path <= drain_pkg::PATH_500;
        endcase
      end
    end
  end

endmodule

/* File: verification/drain_chk.sv */
`timescale 1ns/10ps
module drain_chk
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        scl_in,
  input wire logic        sda_oe_n,
  input wire logic        sda_out,
  input wire logic [10:0] rail_en,
  input wire logic [32:0] drain_path
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  for (genvar g = 0; g < 11; g++)
  begin : rail
    a_path_off_en: assert property (
      rail_en[g] [*3] |-> drain_path[3*g +: 3] == 3'h0)
      else $error("path on while rail enabled");
    a_off_stays: assert property (
      $fell(rail_en[g]) |-> (drain_path[3*g +: 3] == 3'h0) [*8])
      else $error("path back on after disable");
    a_code_legal: assert property (
      $onehot0(drain_path[3*g +: 3]))
      else $error("path not one of the four codes");
  end
  // bus lag plus strobe, field and path stages stay inside eight cycles
  a_path_hold: assert property (
    ($stable(scl_in) && $stable(rail_en)) [*8] |-> $stable(drain_path))
    else $error("path moved without write or enable");
  a_oe_scl_low: assert property (
    $changed(sda_oe_n) |-> !scl_in)
    else $error("data line moved while clock high");
  a_oe_stands: assert property (
    $fell(sda_oe_n) |-> !sda_oe_n [*6])
    else $error("drive too short");
  a_drive_low: assert property (
    !sda_oe_n |-> !sda_out)
    else $error("driving a high level");
  a_fall_lag: assert property (
    $fell(sda_oe_n) |-> !$past(scl_in, 2))
    else $error("drive began too soon after clock fall");
endmodule

bind rail_discharge_control_regs drain_chk drain_chk_i
(.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_oe_n(sda_oe_n),
 .sda_out(sda_out), .rail_en(rail_en), .drain_path(drain_path));

/* File: verification/i2c_host.sv */
`timescale 1ns/10ps
module i2c_host
#(
  parameter logic [6:0] ADDR = drain_pkg::BUS_ADDR_DEF
)
(
  input  wire logic       sys_clk,
  input  wire logic       sda,
  output logic            scl,
  output logic            sda_drv_n,
  output logic            done,
  output logic [7:0]      rd_byte
);
  logic a;
  initial
  begin
    scl = 1'b1;
    sda_drv_n = 1'b1;
    done = 1'b0;
    rd_byte = 8'h00;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // data moves mid-low, sampled mid-high: eight cycles each half
  task automatic bit_io(input logic b, output logic r);
    sda_drv_n = b;
    hw(4);
    scl = 1'b1;
    hw(4);
    r = sda;
    hw(4);
    scl = 1'b0;
    hw(4);
  endtask
  task automatic start();
    bit_io(1'b1, a);
    sda_drv_n = 1'b1;
    scl = 1'b1;
    hw(4);
    sda_drv_n = 1'b0;
    hw(4);
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] w, input logic nack, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
      bit_io(w[i], r[i]);
    bit_io(nack, a);
  endtask
  task automatic head(input logic [7:0] p);
    logic [7:0] r;
    start();
    xfer({ADDR, 1'b0}, 1'b1, r);
    xfer(p, 1'b1, r);
  endtask
  task automatic stop();
    sda_drv_n = 1'b0;
    hw(4);
    scl = 1'b1;
    hw(4);
    sda_drv_n = 1'b1;
    hw(8);
  endtask
  task automatic wr(input logic [7:0] p, input logic [23:0] d, input int n);
    logic [7:0] r;
    head(p);
    for (int i = 0; i < n; i++)
      xfer(d[8*i +: 8], 1'b1, r);
    stop();
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    logic [7:0] r;
    head(p);
    start();
    xfer({ADDR, 1'b1}, 1'b1, r);
    for (int i = 0; i < n; i++)
    begin
      xfer(8'hFF, i == n - 1, r);
      rd_byte = r;
      done = 1'b1;
      hw(1);
      done = 1'b0;
    end
    stop();
  endtask
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic        sys_clk;
  logic        rst_n;
  logic        scl;
  logic        sda_drv_n;
  logic        sda_out;
  logic        sda_oe_n;
  logic        done;
  logic [7:0]  rd_byte;
  logic [10:0] rail_en;
  logic [32:0] drain_path;
  logic [32:0] var_path;
  logic [32:0] var_exp;
  logic        var_oe_n;
  logic [23:0] sh;
  logic [31:0] rnd;
  logic [7:0]  q[$];
  int          miscompares;
  int          cmp_count;
  wire         sda;
  assign sda = sda_drv_n & sda_oe_n & var_oe_n;
  rail_discharge_control_regs rail_discharge_control_regs_i
  (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .ce         (1'b1),
    .scl_in     (scl),
    .sda_in     (sda),
    .sda_out    (sda_out),
    .sda_oe_n   (sda_oe_n),
    .rail_en    (rail_en),
    .drain_path (drain_path)
  );
  // other build: load switch resets to no discharge, sits on another address so it must stay quiet
  if (1)
  begin : variant
    rail_discharge_control_regs
    #(
      .BUS_ADDR      (drain_pkg::BUS_ADDR_DEF + 7'h1),
      .LOAD_SW_RESET (drain_pkg::CODE_NONE)
    )
    rail_discharge_control_regs_i
    (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .ce         (1'b1),
      .scl_in     (scl),
      .sda_in     (sda),
      .sda_out    (),
      .sda_oe_n   (var_oe_n),
      .rail_en    (rail_en),
      .drain_path (var_path)
    );
  end
  i2c_host i2c_host_i
  (
    .sys_clk   (sys_clk),
    .sda       (sda),
    .scl       (scl),
    .sda_drv_n (sda_drv_n),
    .done      (done),
    .rd_byte   (rd_byte)
  );
  always #20 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk)
    if (done === 1'b1)
      check({25'h0, rd_byte}, {25'h0, q.pop_front()});
  task automatic settle();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk_path();
    logic [32:0] e;
    logic [1:0]  c;
    settle();
    for (int g = 0; g < 11; g++)
    begin
      c = sh[2*g +: 2];
      e[3*g +: 3] = (rail_en[g] || c == 2'h0) ? 3'h0 : 3'h1 << (c - 2'h1);
    end
    check(drain_path, e);
  endtask
  // enabled rails lose their code, so the shadow must forget it too
  task automatic rd_all();
    for (int g = 0; g < 11; g++)
      if (rail_en[g])
        sh[2*g +: 2] = 2'h0;
    sh[23:22] = drain_pkg::RSVD_C;
    chk_path();
    for (int i = 0; i < 3; i++)
      q.push_back(sh[8*i +: 8]);
    i2c_host_i.rd(drain_pkg::REG_A_OFS, 3);
  endtask
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    miscompares++;
    finish_test();
  end
  initial
  begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    rail_en = 11'h000;
    rnd = 32'h959b_e911;
    miscompares = 0;
    cmp_count = 0;
    sh = 24'h15_5555;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    settle();
    for (int g = 0; g < 11; g++)
      var_exp[3*g +: 3] = (g == drain_pkg::LOAD_SW_RAIL) ? 3'h0 : 3'h1;
    check(var_path, var_exp);
    rd_all();
    $display("test reset done");
    repeat (3)
    begin
      rnd = xs(rnd);
      sh = {rnd[23:8], 8'hE4};
      i2c_host_i.wr(drain_pkg::REG_A_OFS, sh, 3);
      rd_all();
      rnd = xs(rnd);
      rail_en = rnd[10:0];
      rd_all();
      rnd = xs(rnd);
      sh = rnd[23:0];
      i2c_host_i.wr(drain_pkg::REG_A_OFS, sh, 3);
      rd_all();
      rail_en = 11'h000;
      rd_all();
    end
    $display("test write and enable done");
    q.push_back(drain_pkg::UNMAPPED_DATA);
    i2c_host_i.rd(8'h50, 1);
    i2c_host_i.wr(8'h60, rnd[23:0], 1);
    rd_all();
    $display("test unmapped done");
    finish_test();
  end
endmodule
